// *** tb.sv ***
// Self-checking bench of the 16-bit timer/counter
// Assumes tmr_pkg, the register header and the pin source are compiled first
`include "tmr_regs.svh"
`default_nettype none

`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import tmr_pkg::*;

  // ****************************************************************
  // Signals and bench state
  // ****************************************************************
  logic       ref_clk_in  = 1'b0;      // 250 MHz clock
  logic       rst_b_in    = 1'b0;      // Reset, active low
  logic [3:0] addr_in     = 4'h0;      // Register index
  tmr_word_t  wdata_in    = 16'h0000;  // Write data
  logic       wr_in       = 1'b0;      // Write strobe
  logic       rd_in       = 1'b0;      // Read strobe
  logic       idle_in     = 1'b0;      // Processor Idle
  logic       sleep_in    = 1'b0;      // Processor Sleep
  tmr_word_t  rdata_out;               // Read data
  logic       irq_req_out;             // Event request
  wire logic  cnt_pin;                 // Count pin from the source
  wire logic  gate_pin;                // Gate pin from the source
  int         failures    = 0;         // Mismatch count
  int         comparisons = 0;         // Compare count
  integer     seed        = 32'h0700;  // Fixed random seed
  tmr_word_t  v;                       // Scratch read word
  tmr_word_t  w;                       // Scratch write word
  int         p;                       // Period under test
  int         n;                       // Prescale ratio
  int         k;                       // Cycle or edge count
  // External-source table: control word, Sleep level, expected mode
  tmr_word_t  ext_ctl [4] = '{16'h8006, 16'h8002, 16'h8046, 16'h8006};
  logic       ext_slp [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  tmr_mode_t  ext_md  [4] = '{TMR_MODE_SYNC, TMR_MODE_ASYNC, TMR_MODE_SYNC, TMR_MODE_SYNC};

  always #2 ref_clk_in = ~ref_clk_in;  // 4 ns period

  tmr_top dut (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .external_count_pin_in(cnt_pin), .gate_pin_in(gate_pin), .idle_in(idle_in),
    .sleep_in(sleep_in), .irq_req_out(irq_req_out));
  tmr_pin_src src (.count_pin_out(cnt_pin), .gate_pin_out(gate_pin));

  // ****************************************************************
  // Expectations and bus tasks
  // ****************************************************************
  // Prescale ratio of a select code
  function automatic int div_of(input int code);
    return (code == 3) ? 256 : (code == 2) ? 64 : (code == 1) ? 8 : 1;
  endfunction

  // One write; a gap cycle follows so the strobe never toggles twice at one edge
  task automatic wr(input logic [3:0] a, input tmr_word_t d);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge ref_clk_in);
    wr_in    <= 1'b0;
    @(posedge ref_clk_in);
  endtask

  // One read; data stand only in the next cycle, taken mid-cycle
  task automatic rd(input logic [3:0] a, output tmr_word_t d);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge ref_clk_in);
    rd_in   <= 1'b0;
    @(negedge ref_clk_in);
    d = rdata_out;
    @(posedge ref_clk_in);
  endtask

  // Mode field of the status word
  task automatic chk_mode(input tmr_mode_t m);
    rd(`TMR_ADDR_STATUS, v);
    `CHK(v[8:4], m)
  endtask

  // Count moves, or stands, over 40 cycles
  task automatic moves(input logic e);
    rd(`TMR_ADDR_COUNT, v);
    repeat (40) @(posedge ref_clk_in);
    rd(`TMR_ADDR_COUNT, w);
    `CHK(v !== w, e)
  endtask

  // Request level, sampled clear of the edge
  task automatic chk_irq(input logic e);
    @(negedge ref_clk_in);
    `CHK(irq_req_out, e)
    @(posedge ref_clk_in);
  endtask

  // Counts, then the verdict
  task automatic final_report();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // Watchdog: the whole sequence needs well under 15000 cycles
  // ****************************************************************
  initial begin
    repeat (30000) @(posedge ref_clk_in);
    failures++;
    final_report();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (3) @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
    @(posedge ref_clk_in);
    // Reset values, reserved bits, unmapped index
    rd(`TMR_ADDR_CONTROL, v);
    `CHK(v, 16'h0000)
    rd(`TMR_ADDR_COUNT, v);
    `CHK(v, 16'h0000)
    chk_mode(TMR_MODE_STOP);
    wr(`TMR_ADDR_CONTROL, 16'h5F89);
    rd(`TMR_ADDR_CONTROL, v);
    `CHK(v, 16'h0000)
    for (int i = 0; i < 4; i++) begin
      // Random word with run low; only bits 15,13,6,5,4,2,1 survive
      w = 16'($random(seed) & 32'h7FFF);
      wr(`TMR_ADDR_CONTROL, w);
      rd(`TMR_ADDR_CONTROL, v);
      `CHK(v, w & 16'hA076)
    end
    wr(4'h7, 16'hFFFF);
    rd(4'h7, v);
    `CHK(v, 16'h0000)
    $display("test registers done");
    // Timer with every prescale code and a small random period
    for (int c = 0; c < 4; c++) begin
      p = 1 + ($random(seed) & 7);
      n = div_of(c);
      wr(`TMR_ADDR_CONTROL, 16'h0000);
      wr(`TMR_ADDR_STATUS, 16'h0003);
      wr(`TMR_ADDR_PERIOD, 16'(p));
      wr(`TMR_ADDR_COUNT, 16'h0000);
      wr(`TMR_ADDR_CONTROL, 16'h8000 | 16'(c << 4));
      k = 0;
      while (irq_req_out !== 1'b1 && k < 3000) begin
        @(negedge ref_clk_in);
        k++;
      end
      @(posedge ref_clk_in);
      `CHK(k >= (p + 1) * n - 2 && k <= (p + 1) * n + 3, 1'b1)
      chk_mode(TMR_MODE_TIMER);
      wr(`TMR_ADDR_CONTROL, 16'h0000);
      rd(`TMR_ADDR_COUNT, v);
      `CHK(v <= 16'(p), 1'b1)
      rd(`TMR_ADDR_STATUS, v);
      `CHK(v[0], 1'b1)
      wr(`TMR_ADDR_STATUS, 16'h0003);
      chk_irq(1'b0);
    end
    wr(`TMR_ADDR_PERIOD, 16'hFFFF);
    $display("test prescale done");
    // Run bit, Idle halt, Idle run
    wr(`TMR_ADDR_COUNT, 16'h0000);
    moves(1'b0);
    wr(`TMR_ADDR_CONTROL, 16'hA000);
    idle_in <= 1'b1;
    moves(1'b0);
    idle_in <= 1'b0;
    moves(1'b1);
    wr(`TMR_ADDR_CONTROL, 16'h8000);
    idle_in <= 1'b1;
    moves(1'b1);
    idle_in <= 1'b0;
    // Internal timer must stand still in Sleep
    sleep_in <= 1'b1;
    moves(1'b0);
    sleep_in <= 1'b0;
    $display("test idle done");
    // External source: sync, async in Sleep, gate ignored, sync in Sleep
    for (int i = 0; i < 4; i++) begin
      k = 3 + ($random(seed) & 7);
      wr(`TMR_ADDR_CONTROL, 16'h0000);
      wr(`TMR_ADDR_COUNT, 16'h0000);
      wr(`TMR_ADDR_CONTROL, ext_ctl[i]);
      chk_mode(ext_md[i]);
      sleep_in <= ext_slp[i];
      src.edges(k);
      repeat (6) @(posedge ref_clk_in);
      sleep_in <= 1'b0;
      wr(`TMR_ADDR_CONTROL, 16'h0000);
      rd(`TMR_ADDR_COUNT, v);
      if (ext_slp[i] && ext_md[i] == TMR_MODE_SYNC) begin
        k = 0;
      end
      `CHK(v, 16'(k))
    end
    $display("test external done");
    // Gated accumulation and the gate-fall event
    wr(`TMR_ADDR_STATUS, 16'h0003);
    wr(`TMR_ADDR_COUNT, 16'h0000);
    wr(`TMR_ADDR_CONTROL, 16'h8040);
    chk_mode(TMR_MODE_GATED);
    moves(1'b0);
    chk_irq(1'b0);
    k = 20 + ($random(seed) & 31);
    src.gate_span(k * 4);
    repeat (8) @(posedge ref_clk_in);
    rd(`TMR_ADDR_COUNT, v);
    `CHK(v >= 16'(k - 2) && v <= 16'(k + 2), 1'b1)
    rd(`TMR_ADDR_STATUS, v);
    `CHK(v[1], 1'b1)
    chk_irq(1'b1);
    $display("test gated done");
    final_report();
  end
endmodule

`default_nettype wire

// *** tmr_pin_src.sv ***
// Behavioural source of the count pin and the gate pin of the timer
// Assumes the timer samples both pins through two flops on its clock
`default_nettype none

module tmr_pin_src (
  // Pins toward the timer
  output logic count_pin_out,
  output logic gate_pin_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************************************
  // Pin drivers
  // ****************************************************************
  // Both pins rest low between bursts, like a pulled-down line
  initial begin
    count_pin_out = 1'b0;
    gate_pin_out  = 1'b0;
  end

  // Burst of rising edges; each level lasts 13 ns so no edge is lost
  task automatic edges(input int num);
    for (int i = 0; i < num; i++) begin
      #13 count_pin_out = 1'b1;
      #13 count_pin_out = 1'b0;
    end
  endtask

  // Gate high for a span, then low to give one falling edge;
  // the 1 ns lead keeps both changes off the sampling edge
  task automatic gate_span(input int span_ns);
    #1 gate_pin_out = 1'b1;
    #(span_ns) gate_pin_out = 1'b0;
  endtask
endmodule

`default_nettype wire

// *** tmr_pkg.sv ***
// Types shared by the 16-bit timer/counter block
// Assumes the register header is compiled alongside
`default_nettype none

package tmr_pkg;

  // ****************************************************************
  // Register word and operating mode
  // ****************************************************************
  typedef logic [15:0] tmr_word_t;  // One register word

  // One-hot operating mode of the counter
  typedef enum logic [4:0] {
    TMR_MODE_STOP  = 5'b0_0001,
    TMR_MODE_TIMER = 5'b0_0010,
    TMR_MODE_GATED = 5'b0_0100,
    TMR_MODE_SYNC  = 5'b0_1000,
    TMR_MODE_ASYNC = 5'b1_0000
  } tmr_mode_t;

endpackage

`default_nettype wire

// *** tmr_prescale.sv ***
// Input clock prescaler of the timer: 1, 8, 64 or 256 ticks per count
// Assumes tick_in is a one-cycle strobe on ref_clk_in
`include "tmr_regs.svh"
`default_nettype none

module tmr_prescale #(
  parameter int CW = 8  // Prescale counter width
) (
  // Clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       rst_b_in,
  // Control
  input  wire logic       clear_in,
  input  wire logic [1:0] sel_in,
  // Ticks
  input  wire logic       tick_in,
  output logic            tick_out
);

  logic [CW-1:0] div_ff;   // Ticks seen since last count
  logic [CW-1:0] nxt_div;
  logic [CW-1:0] limit;    // Terminal count of the chosen ratio

  // Ratio code to terminal count
  function automatic logic [CW-1:0] term_count(input logic [1:0] sel);
    case (sel)
      2'b11:   term_count = CW'(`TMR_DIV_256_TC);
      2'b10:   term_count = CW'(`TMR_DIV_64_TC);
      2'b01:   term_count = CW'(`TMR_DIV_8_TC);
      default: term_count = CW'(`TMR_DIV_1_TC);
    endcase
  endfunction

  // Divider next state; a clear discards partial progress
  always_comb begin
    limit    = term_count(sel_in);
    tick_out = tick_in && (div_ff >= limit);
    nxt_div  = div_ff;
    if (clear_in) begin
      nxt_div = '0;
    end else if (tick_out) begin
      nxt_div = '0;
    end else if (tick_in) begin
      nxt_div = div_ff + CW'(1);
    end
  end

  // Divider register
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      div_ff <= '0;
    end else begin
      div_ff <= nxt_div;
    end
  end

endmodule

`default_nettype wire

// *** tmr_regs.svh ***
// Register offsets, field positions, reset values and prescale counts
// Assumes inclusion by every file of the 16-bit timer/counter block
`ifndef TMR_REGS_SVH
`define TMR_REGS_SVH

// ****************************************************************
// Register word indices on the plain register port
// ****************************************************************
`define TMR_ADDR_CONTROL 4'h0
`define TMR_ADDR_PERIOD  4'h1
`define TMR_ADDR_COUNT   4'h2
`define TMR_ADDR_STATUS  4'h3

// ****************************************************************
// Control register field positions
// ****************************************************************
`define TMR_BIT_RUN      15
`define TMR_BIT_IDLE     13
`define TMR_BIT_GATE     6
`define TMR_BIT_PRE_HI   5
`define TMR_BIT_PRE_LO   4
`define TMR_BIT_SYNC     2
`define TMR_BIT_SRC      1
`define TMR_CTRL_MASK    16'hA076

// ****************************************************************
// Status register field positions
// ****************************************************************
`define TMR_STAT_MATCH   0
`define TMR_STAT_GFALL   1
`define TMR_STAT_MODE_LO 4
`define TMR_STAT_MODE_HI 8

// ****************************************************************
// Reset values
// ****************************************************************
`define TMR_RST_CONTROL  16'h0000
`define TMR_RST_PERIOD   16'hFFFF
`define TMR_RST_COUNT    16'h0000

// ****************************************************************
// Prescaler terminal counts (ratio minus one)
// ****************************************************************
`define TMR_DIV_1_TC     8'h00
`define TMR_DIV_8_TC     8'h07
`define TMR_DIV_64_TC    8'h3F
`define TMR_DIV_256_TC   8'hFF

`endif

// *** tmr_sync.sv ***
// Two-flop synchroniser for pin levels entering the timer clock domain
// Assumes inputs are asynchronous to ref_clk_in
`default_nettype none

module tmr_sync #(
  parameter int WIDTH = 2  // Number of levels carried across
) (
  // Clock and reset
  input  wire logic             ref_clk_in,
  input  wire logic             rst_b_in,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;      // First stage, read only by second stage
  logic [WIDTH-1:0] sync_ff;      // Second stage, safe to use
  logic [WIDTH-1:0] nxt_meta;
  logic [WIDTH-1:0] nxt_sync;

  // Next values of both stages
  always_comb begin
    nxt_meta = async_in;
    nxt_sync = meta_ff;
  end

  // Stage registers
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign sync_out = sync_ff;

endmodule

`default_nettype wire

// *** tmr_top.sv ***
// Sixteen-bit timer/counter with control, period, count and status words
// Assumes a same-clock register master and asynchronous count/gate pins
//
// Summary of operation
// - One 16-bit interval timer or counter.
// - Modes: timer, synchronous counter, asynchronous counter.
// - Interrupt on period match or gate fall.
// - Run bit 15 starts and stops counting.
// - Idle-halt bit 13 stops counting in Idle.
// - Gate bit 6 ignored with external source.
// - Prescale bits 5-4 select 1,8,64,256.
// - Sync bit 2 matters only for external source.
// - Source bit 1 selects external rising edges.
// - Unimplemented control bits read zero, ignore writes.
// - Implemented control bits read/write, reset zero.
// - Timer may run in Idle; in Sleep only async counting runs.
`include "tmr_regs.svh"
`default_nettype none

module tmr_top (
  // Clock and reset
  input  wire logic             ref_clk_in,
  input  wire logic             rst_b_in,
  // Register port
  input  wire logic [3:0]       addr_in,
  input  wire tmr_pkg::tmr_word_t wdata_in,
  input  wire logic             wr_in,
  input  wire logic             rd_in,
  output tmr_pkg::tmr_word_t    rdata_out,
  // Pins
  input  wire logic             external_count_pin_in,
  input  wire logic             gate_pin_in,
  // Power state of the processor
  input  wire logic             idle_in,
  input  wire logic             sleep_in,
  // Event request
  output logic                  irq_req_out
);

  import tmr_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  tmr_word_t ctrl_ff;           // timer_one_control
  tmr_word_t nxt_ctrl;
  tmr_word_t period_ff;         // period_value
  tmr_word_t nxt_period;
  tmr_word_t count_ff;          // Running count
  tmr_word_t nxt_count;
  tmr_word_t rdata_ff;          // Read data, valid one cycle after strobe
  tmr_word_t nxt_rdata;
  tmr_mode_t mode_ff;           // Registered operating mode
  tmr_mode_t nxt_mode;
  logic      match_flag_ff;     // Sticky period match flag
  logic      nxt_match_flag;
  logic      gfall_flag_ff;     // Sticky gate falling-edge flag
  logic      nxt_gfall_flag;
  logic      ext_prev_ff;       // Last synchronised count pin level
  logic      gate_prev_ff;      // Last synchronised gate level
  logic      ext_s;             // Synchronised count pin
  logic      gate_s;            // Synchronised gate pin
  logic      ext_rise;          // Rising edge of count pin
  logic      gate_fall;         // Falling edge of gate pin
  logic      timer_run;
  logic      idle_halt;
  logic      gated_accumulate;
  logic      ext_clock_sync;
  logic      clock_source_bit;
  logic [1:0] prescale_select;
  logic      active;            // Counter allowed to advance
  logic      src_tick;          // Raw tick before prescaler
  logic      count_tick;        // Prescaled tick
  logic      wr_count;          // Software writes the count
  logic      clr_match;
  logic      clr_gfall;

  // ****************************************************************
  // Pin synchronisation and edge detection
  // ****************************************************************
  tmr_sync #(
    .WIDTH (2)
  ) u_sync (
    .ref_clk_in (ref_clk_in),
    .rst_b_in   (rst_b_in),
    .async_in   ({gate_pin_in, external_count_pin_in}),
    .sync_out   ({gate_s, ext_s})
  );

  // Edges from the safe stage and its delayed copy
  always_comb begin
    ext_rise  = ext_s && !ext_prev_ff;
    gate_fall = !gate_s && gate_prev_ff;
  end

  // Delayed pin copies
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ext_prev_ff  <= 1'b0;
      gate_prev_ff <= 1'b0;
    end else begin
      ext_prev_ff  <= ext_s;
      gate_prev_ff <= gate_s;
    end
  end

  // ****************************************************************
  // Control fields and mode decode
  // ****************************************************************
  always_comb begin
    timer_run        = ctrl_ff[`TMR_BIT_RUN];
    idle_halt        = ctrl_ff[`TMR_BIT_IDLE];
    gated_accumulate = ctrl_ff[`TMR_BIT_GATE];
    ext_clock_sync   = ctrl_ff[`TMR_BIT_SYNC];
    clock_source_bit = ctrl_ff[`TMR_BIT_SRC];
    prescale_select  = ctrl_ff[`TMR_BIT_PRE_HI:`TMR_BIT_PRE_LO];
    // Mode lags a control write by one cycle
    if (!timer_run) begin
      nxt_mode = TMR_MODE_STOP;
    end else if (clock_source_bit) begin
      // Gate bit plays no part here
      nxt_mode = ext_clock_sync ? TMR_MODE_SYNC : TMR_MODE_ASYNC;
    end else begin
      // Sync bit plays no part here
      nxt_mode = gated_accumulate ? TMR_MODE_GATED : TMR_MODE_TIMER;
    end
  end

  // ****************************************************************
  // Count source and enable
  // ****************************************************************
  always_comb begin
    // Idle halts only when asked; Sleep stops all but async counting
    active = (mode_ff != TMR_MODE_STOP)
             && !(idle_in && idle_halt)
             && (!sleep_in || mode_ff == TMR_MODE_ASYNC);
    case (mode_ff)
      TMR_MODE_TIMER: src_tick = active;
      TMR_MODE_GATED: src_tick = active && gate_s;
      TMR_MODE_SYNC:  src_tick = active && ext_rise;
      TMR_MODE_ASYNC: src_tick = active && ext_rise;
      default:        src_tick = 1'b0;
    endcase
  end

  tmr_prescale #(
    .CW (8)
  ) u_pre (
    .ref_clk_in (ref_clk_in),
    .rst_b_in   (rst_b_in),
    .clear_in   (mode_ff == TMR_MODE_STOP),
    .sel_in     (prescale_select),
    .tick_in    (src_tick),
    .tick_out   (count_tick)
  );

  // ****************************************************************
  // Registers, counter and flags: next values
  // ****************************************************************
  always_comb begin
    wr_count       = wr_in && (addr_in == `TMR_ADDR_COUNT);
    clr_match      = wr_in && (addr_in == `TMR_ADDR_STATUS) && wdata_in[`TMR_STAT_MATCH];
    clr_gfall      = wr_in && (addr_in == `TMR_ADDR_STATUS) && wdata_in[`TMR_STAT_GFALL];
    nxt_ctrl       = ctrl_ff;
    nxt_period     = period_ff;
    nxt_count      = count_ff;
    nxt_match_flag = match_flag_ff && !clr_match;
    nxt_gfall_flag = gfall_flag_ff && !clr_gfall;
    // Reserved control bits never store
    if (wr_in && addr_in == `TMR_ADDR_CONTROL) begin
      nxt_ctrl = wdata_in & `TMR_CTRL_MASK;
    end
    if (wr_in && addr_in == `TMR_ADDR_PERIOD) begin
      nxt_period = wdata_in;
    end
    // Software load wins over a count in the same cycle
    if (wr_count) begin
      nxt_count = wdata_in;
    end else if (count_tick) begin
      nxt_count = (count_ff == period_ff) ? 16'h0000 : count_ff + 16'h0001;
    end
    // Hardware set wins over a software clear
    if (count_tick && count_ff == period_ff) begin
      nxt_match_flag = 1'b1;
    end
    if (mode_ff == TMR_MODE_GATED && gate_fall) begin
      nxt_gfall_flag = 1'b1;
    end
    // Read mux; unmapped words read zero
    case (addr_in)
      `TMR_ADDR_CONTROL: nxt_rdata = ctrl_ff;
      `TMR_ADDR_PERIOD:  nxt_rdata = period_ff;
      `TMR_ADDR_COUNT:   nxt_rdata = count_ff;
      `TMR_ADDR_STATUS:  nxt_rdata = {7'h00, mode_ff, 2'b00, gfall_flag_ff, match_flag_ff};
      default:           nxt_rdata = 16'h0000;
    endcase
    if (!rd_in) begin
      nxt_rdata = 16'h0000;
    end
  end

  // ****************************************************************
  // Registers, counter and flags: storage
  // ****************************************************************
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_ff       <= `TMR_RST_CONTROL;
      period_ff     <= `TMR_RST_PERIOD;
      count_ff      <= `TMR_RST_COUNT;
      rdata_ff      <= 16'h0000;
      mode_ff       <= TMR_MODE_STOP;
      match_flag_ff <= 1'b0;
      gfall_flag_ff <= 1'b0;
    end else begin
      ctrl_ff       <= nxt_ctrl;
      period_ff     <= nxt_period;
      count_ff      <= nxt_count;
      rdata_ff      <= nxt_rdata;
      mode_ff       <= nxt_mode;
      match_flag_ff <= nxt_match_flag;
      gfall_flag_ff <= nxt_gfall_flag;
    end
  end

  assign rdata_out   = rdata_ff;
  // Level request while either flag stands
  assign irq_req_out = match_flag_ff || gfall_flag_ff;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_wrap;
    count_tick && (count_ff == period_ff) && !wr_count;
  endsequence

  sequence s_cleared;
    (count_ff == 16'h0000) && match_flag_ff;
  endsequence

  property p_stopped_holds;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      (mode_ff == TMR_MODE_STOP) && !wr_count |=> $stable(count_ff);
  endproperty
  a_stopped_holds: assert property (p_stopped_holds)
    else $error("count moved while stopped");

  property p_idle_halt;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      idle_in && idle_halt && !wr_count |=> $stable(count_ff);
  endproperty
  a_idle_halt: assert property (p_idle_halt)
    else $error("count moved in idle with halt set");

  property p_wrap;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      s_wrap |=> s_cleared;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("match did not clear count and set flag");

  property p_reserved_zero;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      rd_in && addr_in == `TMR_ADDR_CONTROL |=> (rdata_out & ~`TMR_CTRL_MASK) == 16'h0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved control bits read nonzero");

  property p_ctrl_write;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      wr_in && addr_in == `TMR_ADDR_CONTROL
      |=> ctrl_ff == ($past(wdata_in) & `TMR_CTRL_MASK);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("control write not stored");

  property p_gate_fall;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      mode_ff == TMR_MODE_GATED && gate_fall |=> gfall_flag_ff ##0 irq_req_out;
  endproperty
  a_gate_fall: assert property (p_gate_fall)
    else $error("gate fall did not raise request");

  property p_ext_no_gate;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      timer_run && clock_source_bit |=> mode_ff != TMR_MODE_GATED;
  endproperty
  a_ext_no_gate: assert property (p_ext_no_gate)
    else $error("gated mode with external source");

  property p_sleep_stop;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      sleep_in && mode_ff == TMR_MODE_TIMER |-> !count_tick;
  endproperty
  a_sleep_stop: assert property (p_sleep_stop)
    else $error("internal timer counted in sleep");

  property p_timer_step;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      mode_ff == TMR_MODE_TIMER && prescale_select == 2'b00 && !idle_in && !sleep_in
      && !wr_count && count_ff != period_ff |=> count_ff == $past(count_ff) + 16'h0001;
  endproperty
  a_timer_step: assert property (p_timer_step)
    else $error("timer at 1:1 did not step by one");

endmodule

`default_nettype wire
